/* pmta_top.sv */
// table access unit: pointer, latch, reset control and program memory port
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/10ps

// How it works
// - program memory is 16-bit, data is 8-bit; all traffic passes the latch
// - table accesses are per byte, any byte address, no alignment
// - pointer is upper, high and low byte registers joined into 22 bits
// - low 21 bits address program bytes; top bit selects id/config space
// - automatic pointer steps touch only the low 21 bits
// - four pointer updates: none, post-increment, post-decrement, pre-increment
// - a table read loads the addressed program byte into the latch
// - long-write enable plus programming voltage allows long internal writes
// - long-write enable ignores software clears; only power-on or master clear
// - with long-write enable clear internal writes are off; external unaffected
// - bit 7 enables two interrupt priority levels when set
// - a reset instruction clears bit 4; software sets it again
// - time-out flag set by power-up, watchdog clear, sleep; cleared by time-out
// - power-down flag set by power-up or watchdog clear; cleared by sleep
// - power-on reset clears bit 1; software sets it afterwards
// - brown-out reset clears bit 0; software sets it again
// - with brown-out enabled, bit 0 reads 1 after power-on reset
// - bit 5 reads 0; reset values 0,0,-,1,1,1,0,0
// - even address loads holding byte; odd address starts the long word write
// - with long-write enable clear an internal write is short, memory unchanged
module pmta_top #(
  parameter int INT_MEM_BYTES = pmta_pkg::PMTA_INT_BYTES
) (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic [11:0] wb_adr_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic wb_we_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic master_clear_reset_in,
  input wire logic brownout_reset_in,
  input wire logic reset_instruction_in,
  input wire logic watchdog_timeout_in,
  input wire logic watchdog_clear_instruction_in,
  input wire logic sleep_instruction_in,
  input wire logic brownout_enable_config_in,
  input wire logic programming_voltage_in,
  output pmta_pkg::pmta_pm_req_t pm_req_out,
  input wire logic [7:0] pm_rdata_in,
  input wire logic pm_ack_in,
  output logic interrupt_priority_enable_out,
  output logic long_write_enable_out
);
  import pmta_pkg::*;

  // whole module state in one record
  typedef struct packed {
    pmta_state_t st;
    logic ack;
    logic [31:0] dat;
    logic [7:0] latch;
    logic [7:0] ptr_u;
    logic [7:0] ptr_h;
    logic [7:0] ptr_l;
    logic [7:0] hold;
    pmta_reset_control_flags_t rc;
    logic por_pend;
    logic op_rd;
    pmta_upd_t op_upd;
    pmta_pm_req_t pm;
  } pmta_regs_t;

  pmta_regs_t r_q;
  pmta_regs_t r_d;

  logic [21:0] ptr;
  logic [21:0] acc_addr;
  logic [21:0] ptr_inc;
  logic [21:0] ptr_dec;
  logic acc_internal;
  logic bus_req;
  logic [1:0] cmd_mode;
  logic [7:0] reset_control_flags_rd;

  // pointer view and arithmetic on the low 21 bits only
  assign ptr = {r_q.ptr_u[5:0], r_q.ptr_h, r_q.ptr_l};
  assign ptr_inc = {ptr[21], ptr[20:0] + PMTA_ONE};
  assign ptr_dec = {ptr[21], ptr[20:0] - PMTA_ONE};
  assign cmd_mode = wb_dat_in[PMTA_CMD_MODE_LO +: 2];
  assign acc_addr = (pmta_upd_t'(cmd_mode) == PMTA_UPD_PRE_INC) ? ptr_inc : ptr;
  // top bit space is on-chip, so it counts as internal memory
  assign acc_internal = acc_addr[21] ||
                        ({11'h0, acc_addr[20:0]} < 32'(INT_MEM_BYTES));
  assign bus_req = wb_cyc_in && wb_stb_in && !r_q.ack;

  // read view of the reset control register, bit 5 forced low
  always_comb begin
    reset_control_flags_rd = 8'h00;
    reset_control_flags_rd[PMTA_RC_INTERRUPT_PRIORITY_ENABLE] = r_q.rc.interrupt_priority_enable;
    reset_control_flags_rd[PMTA_RC_LONG_WRITE_ENABLE] = r_q.rc.long_write_enable;
    reset_control_flags_rd[PMTA_RC_RI] = r_q.rc.ri;
    reset_control_flags_rd[PMTA_RC_TO] = r_q.rc.to;
    reset_control_flags_rd[PMTA_RC_PD] = r_q.rc.pd;
    reset_control_flags_rd[PMTA_RC_POR] = r_q.rc.por;
    reset_control_flags_rd[PMTA_RC_BOR] = r_q.rc.bor;
  end

  // next state: bus slave, table engine, reset flag events
  always_comb begin
    r_d = r_q;
    r_d.ack = 1'b0;

    // brown-out flag is fixed up one cycle after power-on release
    if (r_q.por_pend) begin
      r_d.por_pend = 1'b0;
      r_d.rc.bor = brownout_enable_config_in;
    end

    unique case (r_q.st)
      PMTA_S_IDLE: begin
        if (bus_req && !wb_we_in) begin
          r_d.ack = 1'b1;
          unique case (wb_adr_in)
            PMTA_ADR_RESET_CONTROL_FLAGS: r_d.dat = {24'h0, reset_control_flags_rd};
            PMTA_ADR_LATCH: r_d.dat = {24'h0, r_q.latch};
            PMTA_ADR_PTR_LOW: r_d.dat = {24'h0, r_q.ptr_l};
            PMTA_ADR_PTR_HIGH: r_d.dat = {24'h0, r_q.ptr_h};
            PMTA_ADR_PTR_UPPER: r_d.dat = {24'h0, 2'h0, r_q.ptr_u[5:0]};
            PMTA_ADR_STATUS: r_d.dat = {30'h0, programming_voltage_in, 1'b0};
            default: r_d.dat = 32'h0;
          endcase
        end else if (bus_req && wb_we_in) begin
          r_d.dat = 32'h0;
          r_d.ack = 1'b1;
          if (wb_sel_in[0]) begin
            unique case (wb_adr_in)
              PMTA_ADR_RESET_CONTROL_FLAGS: begin
                r_d.rc.interrupt_priority_enable = wb_dat_in[PMTA_RC_INTERRUPT_PRIORITY_ENABLE];
                // software may set but never clear the long-write enable
                r_d.rc.long_write_enable = r_q.rc.long_write_enable | wb_dat_in[PMTA_RC_LONG_WRITE_ENABLE];
                r_d.rc.ri = wb_dat_in[PMTA_RC_RI];
                r_d.rc.to = wb_dat_in[PMTA_RC_TO];
                r_d.rc.pd = wb_dat_in[PMTA_RC_PD];
                r_d.rc.por = wb_dat_in[PMTA_RC_POR];
                r_d.rc.bor = wb_dat_in[PMTA_RC_BOR];
              end
              PMTA_ADR_LATCH: r_d.latch = wb_dat_in[7:0];
              PMTA_ADR_PTR_LOW: r_d.ptr_l = wb_dat_in[7:0];
              PMTA_ADR_PTR_HIGH: r_d.ptr_h = wb_dat_in[7:0];
              PMTA_ADR_PTR_UPPER: r_d.ptr_u = {2'h0, wb_dat_in[5:0]};
              PMTA_ADR_CMD: begin
                // table operation: ack waits until the access is finished
                r_d.ack = 1'b0;
                r_d.op_upd = pmta_upd_t'(cmd_mode);
                r_d.op_rd = !wb_dat_in[PMTA_CMD_WRITE];
                // pre-increment lands in the pointer before the access
                if (pmta_upd_t'(cmd_mode) == PMTA_UPD_PRE_INC) begin
                  {r_d.ptr_u[5:0], r_d.ptr_h, r_d.ptr_l} = ptr_inc;
                end
                r_d.pm.addr = acc_addr;
                r_d.pm.long_wr = 1'b0;
                r_d.pm.we = 1'b0;
                r_d.pm.wdata = 16'h0;
                r_d.st = PMTA_S_DONE;
                if (!wb_dat_in[PMTA_CMD_WRITE]) begin
                  r_d.pm.req = 1'b1;
                  r_d.st = PMTA_S_MEM;
                end else if (!acc_internal) begin
                  // external memory takes single bytes, enable bit ignored
                  r_d.pm.req = 1'b1;
                  r_d.pm.we = 1'b1;
                  r_d.pm.wdata = {8'h0, r_q.latch};
                  r_d.st = PMTA_S_MEM;
                end else if (!acc_addr[0]) begin
                  r_d.hold = r_q.latch;
                end else if (r_q.rc.long_write_enable && programming_voltage_in) begin
                  // odd byte: word goes out as latch high, holding byte low
                  r_d.pm.req = 1'b1;
                  r_d.pm.we = 1'b1;
                  r_d.pm.long_wr = 1'b1;
                  r_d.pm.addr = {acc_addr[21:1], 1'b0};
                  r_d.pm.wdata = {r_q.latch, r_q.hold};
                  r_d.st = PMTA_S_MEM;
                end
                // otherwise a short write: memory left untouched
              end
              default: ;
            endcase
          end
        end
      end
      PMTA_S_MEM: begin
        // long write halts here until memory reports the end of programming
        if (pm_ack_in) begin
          r_d.pm.req = 1'b0;
          r_d.pm.we = 1'b0;
          r_d.pm.long_wr = 1'b0;
          if (r_q.op_rd) begin
            r_d.latch = pm_rdata_in;
          end
          r_d.st = PMTA_S_DONE;
        end
      end
      PMTA_S_DONE: begin
        // post updates after the access, top pointer bit kept
        if (r_q.op_upd == PMTA_UPD_POST_INC) begin
          {r_d.ptr_u[5:0], r_d.ptr_h, r_d.ptr_l} = ptr_inc;
        end else if (r_q.op_upd == PMTA_UPD_POST_DEC) begin
          {r_d.ptr_u[5:0], r_d.ptr_h, r_d.ptr_l} = ptr_dec;
        end
        r_d.ack = 1'b1;
        r_d.st = PMTA_S_IDLE;
      end
      default: r_d.st = PMTA_S_IDLE;
    endcase

    // hardware events come last so they beat a software write in the same cycle
    if (watchdog_clear_instruction_in) begin
      r_d.rc.to = 1'b1;
      r_d.rc.pd = 1'b1;
    end
    if (sleep_instruction_in) begin
      r_d.rc.to = 1'b1;
      r_d.rc.pd = 1'b0;
    end
    if (watchdog_timeout_in) begin
      r_d.rc.to = 1'b0;
    end
    if (reset_instruction_in) begin
      r_d.rc.ri = 1'b0;
    end
    if (brownout_reset_in) begin
      r_d.rc.bor = 1'b0;
      r_d.por_pend = 1'b0;
    end
    // master clear drops the enables and aborts any table operation
    if (master_clear_reset_in) begin
      r_d.rc.interrupt_priority_enable = PMTA_RST_INTERRUPT_PRIORITY_ENABLE;
      r_d.rc.long_write_enable = PMTA_RST_LONG_WRITE_ENABLE;
      r_d.st = PMTA_S_IDLE;
      r_d.ack = 1'b0;
      r_d.pm.req = 1'b0;
      r_d.pm.we = 1'b0;
      r_d.pm.long_wr = 1'b0;
    end
  end

  // single state register; async reset is the power-on reset
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      r_q.st <= PMTA_S_IDLE;
      r_q.ack <= 1'b0;
      r_q.dat <= 32'h0;
      r_q.latch <= 8'h00;
      r_q.ptr_u <= 8'h00;
      r_q.ptr_h <= 8'h00;
      r_q.ptr_l <= 8'h00;
      r_q.hold <= 8'h00;
      r_q.rc.interrupt_priority_enable <= PMTA_RST_INTERRUPT_PRIORITY_ENABLE;
      r_q.rc.long_write_enable <= PMTA_RST_LONG_WRITE_ENABLE;
      r_q.rc.ri <= PMTA_RST_RI;
      r_q.rc.to <= PMTA_RST_TO;
      r_q.rc.pd <= PMTA_RST_PD;
      r_q.rc.por <= PMTA_RST_POR;
      r_q.rc.bor <= PMTA_RST_BOR;
      r_q.por_pend <= 1'b1;
      r_q.op_rd <= 1'b0;
      r_q.op_upd <= PMTA_UPD_NONE;
      r_q.pm <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  // outputs taken straight from the state flops
  assign wb_ack_out = r_q.ack;
  assign wb_dat_out = r_q.dat;
  assign pm_req_out = r_q.pm;
  assign interrupt_priority_enable_out = r_q.rc.interrupt_priority_enable;
  assign long_write_enable_out = r_q.rc.long_write_enable;

endmodule : pmta_top

/* pmta_pkg.sv */
// shared constants and types for the program memory table access unit
package pmta_pkg;

  // register byte addresses on the wishbone slave
  localparam logic [11:0] PMTA_ADR_RESET_CONTROL_FLAGS = 12'hfd0;
  localparam logic [11:0] PMTA_ADR_LATCH = 12'hfe0;
  localparam logic [11:0] PMTA_ADR_PTR_LOW = 12'hfe4;
  localparam logic [11:0] PMTA_ADR_PTR_HIGH = 12'hfe8;
  localparam logic [11:0] PMTA_ADR_PTR_UPPER = 12'hfec;
  localparam logic [11:0] PMTA_ADR_CMD = 12'hff0;
  localparam logic [11:0] PMTA_ADR_STATUS = 12'hff4;

  // reset control register field positions
  localparam int PMTA_RC_INTERRUPT_PRIORITY_ENABLE = 7;
  localparam int PMTA_RC_LONG_WRITE_ENABLE = 6;
  localparam int PMTA_RC_RI = 4;
  localparam int PMTA_RC_TO = 3;
  localparam int PMTA_RC_PD = 2;
  localparam int PMTA_RC_POR = 1;
  localparam int PMTA_RC_BOR = 0;

  // reset control values after power-on
  localparam logic PMTA_RST_INTERRUPT_PRIORITY_ENABLE = 1'b0;
  localparam logic PMTA_RST_LONG_WRITE_ENABLE = 1'b0;
  localparam logic PMTA_RST_RI = 1'b1;
  localparam logic PMTA_RST_TO = 1'b1;
  localparam logic PMTA_RST_PD = 1'b1;
  localparam logic PMTA_RST_POR = 1'b0;
  localparam logic PMTA_RST_BOR = 1'b0;

  // command register fields
  localparam int PMTA_CMD_WRITE = 0;
  localparam int PMTA_CMD_MODE_LO = 1;

  // widths
  localparam int PMTA_PTR_W = 22;
  localparam int PMTA_LOW_W = 21;
  localparam logic [20:0] PMTA_ONE = 21'h1;
  localparam int PMTA_INT_BYTES = 32768;

  // pointer update modes
  typedef enum logic [1:0] {
    PMTA_UPD_NONE = 2'h0,
    PMTA_UPD_POST_INC = 2'h1,
    PMTA_UPD_POST_DEC = 2'h2,
    PMTA_UPD_PRE_INC = 2'h3
  } pmta_upd_t;

  typedef enum logic [2:0] {
    PMTA_S_IDLE = 3'b001,
    PMTA_S_MEM = 3'b010,
    PMTA_S_DONE = 3'b100
  } pmta_state_t;

  // program memory request bundle
  typedef struct packed {
    logic req;
    logic we;
    logic long_wr;
    logic [21:0] addr;
    logic [15:0] wdata;
  } pmta_pm_req_t;

  // reset control bits held in flops
  typedef struct packed {
    logic interrupt_priority_enable;
    logic long_write_enable;
    logic ri;
    logic to;
    logic pd;
    logic por;
    logic bor;
  } pmta_reset_control_flags_t;

endpackage : pmta_pkg

/* pmta_pm_model.sv */
// behavioural program memory answering table requests after a chosen wait
`timescale 1ns/10ps
module pmta_pm_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire pmta_pkg::pmta_pm_req_t req_in,
  input wire logic [1:0] wait_in,
  output logic [7:0] rdata_out,
  output logic ack_out
);
  import pmta_pkg::*;
  byte unsigned mem [int];
  int cnt;
  // data toggles outside the ack cycle so a stale sample never passes
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ack_out <= 1'b0;
      rdata_out <= 8'h5a;
      cnt <= 0;
    end else begin
      ack_out <= 1'b0;
      rdata_out <= ~rdata_out;
      cnt <= 0;
      if (req_in.req && !ack_out) begin
        cnt <= cnt + 1;
        if (cnt >= int'(wait_in)) begin
          ack_out <= 1'b1;
          rdata_out <= mem.exists(req_in.addr) ? mem[req_in.addr] : 8'(req_in.addr * 7 + 3);
          if (req_in.we) begin
            mem[req_in.addr] = req_in.wdata[7:0];
          end
          if (req_in.we && req_in.long_wr) begin
            mem[req_in.addr + 1] = req_in.wdata[15:8];
          end
        end
      end
    end
  end
endmodule : pmta_pm_model

/* pmta_checker.sv */
// assertions on the table access unit ports
`timescale 1ns/10ps
module pmta_checker #(
  parameter int INT_MEM_BYTES = 32768
) (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic [11:0] wb_adr_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic wb_we_in,
  input wire logic wb_stb_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire logic master_clear_reset_in,
  input wire logic programming_voltage_in,
  input wire pmta_pkg::pmta_pm_req_t pm_req_out,
  input wire logic pm_ack_in,
  input wire logic interrupt_priority_enable_out,
  input wire logic long_write_enable_out
);
  import pmta_pkg::*;
  default clocking dc @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  a_long_write_enable_sticky: assert property (long_write_enable_out && !master_clear_reset_in
    |=> long_write_enable_out) else $error("long write enable dropped");
  a_master_clear_pin_clears: assert property (master_clear_reset_in
    |=> !long_write_enable_out && !interrupt_priority_enable_out) else $error("clear kept");
  a_long_gated: assert property (pm_req_out.req && pm_req_out.long_wr
    |-> long_write_enable_out && programming_voltage_in) else $error("ungated long write");
  a_long_even: assert property (pm_req_out.req && pm_req_out.long_wr
    |-> !pm_req_out.addr[0]) else $error("long write odd address");
  a_bit5_zero: assert property (wb_ack_out && !wb_we_in && wb_adr_in == PMTA_ADR_RESET_CONTROL_FLAGS
    |-> wb_dat_out[31:5] == 27'h0 || wb_dat_out[31:8] == 24'h0 && !wb_dat_out[5])
    else $error("reset control read bad");
  a_interrupt_priority_enable_follow: assert property (wb_ack_out && wb_we_in && wb_sel_in[0]
    && wb_adr_in == PMTA_ADR_RESET_CONTROL_FLAGS |=> interrupt_priority_enable_out == $past(wb_dat_in[7]))
    else $error("priority enable not written");
  a_req_hold: assert property (pm_req_out.req && !pm_ack_in && !master_clear_reset_in
    |=> pm_req_out.req && $stable(pm_req_out)) else $error("request moved");
  a_req_release: assert property (pm_req_out.req && pm_ack_in |=> !pm_req_out.req)
    else $error("request held after ack");
  a_reg_answer: assert property ($rose(wb_stb_in) && wb_adr_in != PMTA_ADR_CMD
    |=> wb_ack_out) else $error("register ack late");
  // a command with byte lane 0 off is an ignored write, answered at once
  a_cmd_bounded: assert property ($rose(wb_stb_in) && wb_we_in && wb_sel_in[0]
    && wb_adr_in == PMTA_ADR_CMD |=> !wb_ack_out ##[1:40] wb_ack_out)
    else $error("command ack timing");
  c_long: cover property (pm_req_out.req && pm_req_out.long_wr && pm_ack_in);
  c_read: cover property (pm_req_out.req && !pm_req_out.we && pm_ack_in);
  c_master_clear_pin: cover property (master_clear_reset_in && long_write_enable_out);
endmodule : pmta_checker
bind pmta_top pmta_checker #(.INT_MEM_BYTES(INT_MEM_BYTES)) u_chk (
  .mclk_in(mclk_in),
  .sys_rst_in(sys_rst_in),
  .wb_adr_in(wb_adr_in),
  .wb_dat_in(wb_dat_in),
  .wb_sel_in(wb_sel_in),
  .wb_we_in(wb_we_in),
  .wb_stb_in(wb_stb_in),
  .wb_dat_out(wb_dat_out),
  .wb_ack_out(wb_ack_out),
  .master_clear_reset_in(master_clear_reset_in),
  .programming_voltage_in(programming_voltage_in),
  .pm_req_out(pm_req_out),
  .pm_ack_in(pm_ack_in),
  .interrupt_priority_enable_out(interrupt_priority_enable_out),
  .long_write_enable_out(long_write_enable_out)
);

/* tb_top.sv */
// self-checking bench for the table access unit
`timescale 1ns/10ps
module tb_top;
  import pmta_pkg::*;
  localparam int IMB = 64;
  logic mclk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [11:0] adr = 12'h0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] sel = 4'hf;
  logic we = 1'b0;
  logic stb = 1'b0;
  logic master_clear_pin = 1'b0;
  logic pv = 1'b0;
  logic brownout_enable_config = 1'b1;
  logic [4:0] ev = 5'h0;
  logic [1:0] dly = 2'h0;
  logic [31:0] rdat, dq;
  logic ack, pm_ack, interrupt_priority_enable, long_write_enable;
  logic [7:0] pm_rd;
  pmta_pm_req_t pm;
  int miscompares = 0;
  int checks_done = 0;
  int cyc_n = 0;
  int ptr = 0;
  int lat = 0;
  int hold = 0;
  int rc = 'h1d;
  int am[5] = '{'hfe, 'hef, 'hf7, 'hff, 'hfb};
  int om[5] = '{0, 0, 0, 'h0c, 'h08};
  byte unsigned mem [int];
  always #2 mclk_in = ~mclk_in;
  pmta_top #(.INT_MEM_BYTES(IMB)) DUT (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
    .wb_adr_in(adr), .wb_dat_in(wdat), .wb_sel_in(sel), .wb_we_in(we), .wb_cyc_in(stb),
    .wb_stb_in(stb), .wb_dat_out(rdat), .wb_ack_out(ack), .master_clear_reset_in(master_clear_pin),
    .brownout_reset_in(ev[0]), .reset_instruction_in(ev[1]), .watchdog_timeout_in(ev[2]),
    .watchdog_clear_instruction_in(ev[3]), .sleep_instruction_in(ev[4]),
    .brownout_enable_config_in(brownout_enable_config), .programming_voltage_in(pv), .pm_req_out(pm),
    .pm_rdata_in(pm_rd), .pm_ack_in(pm_ack), .interrupt_priority_enable_out(interrupt_priority_enable),
    .long_write_enable_out(long_write_enable));
  pmta_pm_model PM (.clk_in(mclk_in), .rst_in(sys_rst_in), .req_in(pm), .wait_in(dly),
    .rdata_out(pm_rd), .ack_out(pm_ack));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  // hang guard, far above the roughly 1500 cycles the run needs
  always @(posedge mclk_in) begin
    cyc_n++;
    if (cyc_n == 30000) begin
      miscompares++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // classic cycle: held until ack is sampled, then one idle cycle
  task automatic wb(input logic [11:0] a, input logic w, input int d, output logic [31:0] q);
    adr <= a;
    we <= w;
    wdat <= {24'($urandom()), 8'(d)};
    stb <= 1'b1;
    do @(posedge mclk_in); while (ack !== 1'b1);
    q = rdat;
    stb <= 1'b0;
    @(posedge mclk_in);
  endtask : wb
  task automatic wr(input logic [11:0] a, input int d);
    wb(a, 1'b1, d, dq);
  endtask : wr
  task automatic rd(input logic [11:0] a, input int e);
    wb(a, 1'b0, 0, dq);
    chk(dq, 32'(e));
  endtask : rd
  function automatic int stp(int p, int s);
    return (p & 'h200000) | ((p + s) & 'h1fffff);
  endfunction : stp
  task automatic setp(input int p);
    wr(PMTA_ADR_PTR_LOW, p);
    wr(PMTA_ADR_PTR_HIGH, p >> 8);
    wr(PMTA_ADR_PTR_UPPER, p >> 16);
    ptr = p;
  endtask : setp
  // reference model runs before the command so pre-increment is seen first
  task automatic op(input logic w, input int m);
    @(posedge mclk_in);
    if (w) begin
      lat = $urandom_range(0, 255);
      wr(PMTA_ADR_LATCH, lat);
    end
    dly <= 2'($urandom());
    if (m == 3) ptr = stp(ptr, 1);
    if (!w) lat = mem.exists(ptr) ? mem[ptr] : 8'(ptr * 7 + 3);
    else if (ptr >= IMB && ptr < 'h200000) mem[ptr] = 8'(lat);
    else if (ptr % 2 == 0) hold = lat;
    else if (rc[6] && pv) begin
      mem[ptr - 1] = 8'(hold);
      mem[ptr] = 8'(lat);
    end
    if (m == 1) ptr = stp(ptr, 1);
    if (m == 2) ptr = stp(ptr, -1);
    wr(PMTA_ADR_CMD, m * 2 + int'(w));
    rd(PMTA_ADR_LATCH, lat);
    rd(PMTA_ADR_PTR_LOW, ptr & 'hff);
    rd(PMTA_ADR_PTR_HIGH, (ptr >> 8) & 'hff);
    rd(PMTA_ADR_PTR_UPPER, ptr >> 16);
  endtask : op
  initial begin
    void'($urandom(34164));
    repeat (10) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    rd(PMTA_ADR_RESET_CONTROL_FLAGS, rc);
    rd(12'hf00, 0);
    $display("test reset done");
    wr(PMTA_ADR_RESET_CONTROL_FLAGS, 'hff);
    rc = 'hdf;
    rd(PMTA_ADR_RESET_CONTROL_FLAGS, rc);
    chk(32'({interrupt_priority_enable, long_write_enable}), 32'h3);
    wr(PMTA_ADR_RESET_CONTROL_FLAGS, 'h1f);
    rc = 'h5f;
    rd(PMTA_ADR_RESET_CONTROL_FLAGS, rc);
    for (int i = 0; i < 5; i++) begin
      ev[i] <= 1'b1;
      @(posedge mclk_in);
      ev <= 5'h0;
      @(posedge mclk_in);
      rc = (rc & am[i]) | om[i];
      rd(PMTA_ADR_RESET_CONTROL_FLAGS, rc);
    end
    wr(PMTA_ADR_RESET_CONTROL_FLAGS, 'h1f);
    rc = 'h5f;
    rd(PMTA_ADR_RESET_CONTROL_FLAGS, rc);
    $display("test flags done");
    setp('h3fffff);
    for (int k = 0; k < 48; k++) begin
      if (k % 8 == 4) setp($urandom_range(0, 2 * IMB - 1));
      pv <= 1'($urandom());
      op(1'($urandom()), (k + 1) % 4);
    end
    sel <= 4'he;
    wr(PMTA_ADR_LATCH, ~lat);
    sel <= 4'hf;
    rd(PMTA_ADR_LATCH, lat);
    $display("test pointer done");
    for (int j = 0; j < 3; j++) begin
      if (j == 2) begin
        master_clear_pin <= 1'b1;
        @(posedge mclk_in);
        master_clear_pin <= 1'b0;
        rc = rc & 'h3f;
        rd(PMTA_ADR_RESET_CONTROL_FLAGS, rc);
      end
      pv <= (j != 1);
      setp(16 + 4 * j);
      rd(PMTA_ADR_STATUS, (j != 1) ? 2 : 0);
      op(1'b1, 1);
      op(1'b1, 0);
      setp(16 + 4 * j);
      op(1'b0, 1);
      op(1'b0, 0);
    end
    $display("test long write done");
    // second power-on reset with brown-out reset off: enables must drop too
    wr(PMTA_ADR_RESET_CONTROL_FLAGS, 'hff);
    brownout_enable_config <= 1'b0;
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    rd(PMTA_ADR_RESET_CONTROL_FLAGS, 'h1c);
    chk(32'({interrupt_priority_enable, long_write_enable}), 32'h0);
    $display("test second reset done");
    end_sim();
  end
endmodule : tb_top
